// *** verif/watchdog_with_reset_flags_tb.sv ***
/*
  Self-checking bench for the watchdog with reset-cause flags.
  Assumes the design's register header and APB slave with registered answers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); end end

module watchdog_with_reset_flags_tb;
  localparam logic [7:0] CTRL = `WDT_CTRL_ADDR;
  localparam logic [7:0] STAT = `WDT_STAT_ADDR;
  // Short base period keeps time-outs up to code 1 within a few dozen cycles; code 9 still takes 8192 cycles
  localparam int TICKS = 4;

  logic        sys_clk = 1'b0;
  logic        rst, psel, penable, pwrite, slow_tick, kick, fuse, gie, ack, bor, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  logic [1:0]  tick_cnt;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, wdt_rst;
  int          mismatches, checks_done, n, resets;

  watchdog_with_reset_flags #(.BASE_TICKS(TICKS)) uut (
    .sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .slow_tick_i(slow_tick), .kick_i(kick),
    .always_on_fuse_i(fuse), .global_irq_enable_i(gie), .irq_ack_i(ack),
    .brownout_rst_i(bor), .pin_rst_i(pin), .timeout_irq_o(irq), .wdt_reset_o(wdt_rst));

  always #2 sys_clk = ~sys_clk;

  // Slow oscillator stand-in: one tick every four system cycles
  always @(posedge sys_clk)
  begin
    tick_cnt  <= tick_cnt + 2'h1;
    slow_tick <= (tick_cnt == 2'h3);
    if (wdt_rst === 1'b1)
      resets <= resets + 1;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout_hit();
    mismatches++;
    end_of_test();
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 8);
    if (k >= 8) timeout_hit();
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
    `CHK(e, 1'b0)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    xfer(1'b0, a, 32'h0);
    `CHK({e, q}, {1'b0, 24'h0, x})
  endtask

  // Waits for a reset pulse or the interrupt line; n holds the cycles taken
  task automatic wait_evt(input bit want_rst, input int bound);
    n = 0;
    while ((want_rst ? wdt_rst : irq) !== 1'b1)
    begin
      @(posedge sys_clk);
      n++;
      if (n > bound) timeout_hit();
    end
  endtask

  task automatic src(input logic b, input logic p);
    bor <= b;
    pin <= p;
    @(posedge sys_clk);
    bor <= 1'b0;
    pin <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {slow_tick, ack, bor, pin, gie, fuse, tick_cnt} = '0;
    kick = 1'b1;
    rst = 1'b1;
    mismatches = 0;
    checks_done = 0;
    resets = 0;
    do_reset();
    rd(STAT, 8'h01);
    rd(CTRL, 8'h00);
    xfer(1'b0, 8'h90, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0})
    wr(STAT, 8'hf1);
    rd(STAT, 8'h01);
    wr(STAT, 8'h00);
    rd(STAT, 8'h00);
    src(1'b1, 1'b0);
    rd(STAT, 8'h04);
    src(1'b0, 1'b1);
    rd(STAT, 8'h06);
    wr(STAT, 8'h04);
    rd(STAT, 8'h04);
    wr(STAT, 8'h00);
    rd(STAT, 8'h00);
    // Reset mode; the held kick must keep the counter from expiring
    wr(CTRL, 8'h08);
    rd(CTRL, 8'h08);
    repeat (40) @(posedge sys_clk);
    `CHK(resets, 0)
    kick <= 1'b0;
    wait_evt(1'b1, 40);
    kick <= 1'b1;
    `CHK(n inside {[12:20]}, 1'b1)
    @(posedge sys_clk);
    `CHK(wdt_rst, 1'b0)
    rd(STAT, 8'h08);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h08);
    wr(STAT, 8'h00);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h00);
    // Window that is left to expire
    wr(CTRL, 8'h08);
    wr(CTRL, 8'h18);
    rd(CTRL, 8'h18);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h01);
    rd(CTRL, 8'h01);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h01);
    // Interrupt mode with code 1: twice the base period
    gie <= 1'b1;
    wr(CTRL, 8'h41);
    kick <= 1'b0;
    wait_evt(1'b0, 80);
    kick <= 1'b1;
    `CHK(n inside {[28:40]}, 1'b1)
    gie <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rd(CTRL, 8'hc1);
    ack <= 1'b1;
    @(posedge sys_clk);
    ack <= 1'b0;
    rd(CTRL, 8'h41);
    gie <= 1'b1;
    kick <= 1'b0;
    wait_evt(1'b0, 80);
    kick <= 1'b1;
    wr(CTRL, 8'hc1);
    rd(CTRL, 8'h41);
    // First time-out only interrupts, the second one resets
    wr(CTRL, 8'h49);
    kick <= 1'b0;
    wait_evt(1'b1, 100);
    kick <= 1'b1;
    `CHK(n inside {[56:76]}, 1'b1)
    rd(STAT, 8'h08);
    // Safety level 2
    fuse <= 1'b1;
    do_reset();
    rd(STAT, 8'h01);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h0b);
    rd(CTRL, 8'h08);
    // Reserved code 15 must time out like code 9: 512 base periods
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h2f);
    rd(CTRL, 8'h2f);
    kick <= 1'b0;
    wait_evt(1'b1, 9000);
    kick <= 1'b1;
    `CHK(n inside {[8188:8196]}, 1'b1)
    end_of_test();
  end
endmodule // watchdog_with_reset_flags_tb
`default_nettype wire

// *** verilog/watchdog_pkg.sv ***
/*
  Types shared by the watchdog block.
  Assumes nothing of its surroundings.
*/
package watchdog_pkg;

  // Time-out behaviour selected by {enable, irq enable}
  typedef enum logic [1:0] {
    MODE_STOPPED   = 2'b00,
    MODE_IRQ       = 2'b01,
    MODE_RESET     = 2'b10,
    MODE_IRQ_RESET = 2'b11
  } wdt_mode_type;

endpackage

// *** verilog/watchdog_regs.svh ***
/*
  Register map, field positions, reset values and timing counts of the
  watchdog block. Definitions only; included by bare name.
*/
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// Register indices; the byte address is four times the index
`define WDT_CTRL_INDEX      8'h21
`define WDT_STAT_INDEX      8'h22
`define WDT_CTRL_ADDR       8'h84
`define WDT_STAT_ADDR       8'h88

// Control register fields
`define WDT_CTRL_IRQF_BIT   7
`define WDT_CTRL_IE_BIT     6
`define WDT_CTRL_SEL3_BIT   5
`define WDT_CTRL_CE_BIT     4
`define WDT_CTRL_WDE_BIT    3

// Status register fields
`define WDT_STAT_WDRF_BIT   3
`define WDT_STAT_BROWNOUT_CAUSE_FLAG_BIT   2
`define WDT_STAT_PIN_CAUSE_FLAG_BIT  1
`define WDT_STAT_POWERON_CAUSE_FLAG_BIT   0

// Reset values
`define WDT_SEL_RESET       4'h0
`define WDT_POWERON_CAUSE_FLAG_RESET      1'b1

// Timing
`define WDT_CE_CYCLES       3'h4
`define WDT_SLOW_OSC_KHZ    128
`define WDT_BASE_TICKS      2048
`define WDT_SEL_MAX         4'h9

`endif

// *** verilog/watchdog_with_reset_flags.sv ***
/*
  Watchdog timer with its control register and the reset-cause flags,
  reached over APB (zero-wait, registered answer).
  Assumes the slow oscillator arrives as a one-cycle tick synchronous to
  sys_clk_i, and that rst_i is the power-on reset of the device.
*/
// The implementer's own choice: register access over APB.
// Summary of operation
// - Status bits 7:4 always read zero
// - Watchdog reset sets bit 3; POR or zero-write clears
// - Brown-out reset sets bit 2; POR or zero-write clears
// - Pin reset sets bit 1; POR or zero-write clears
// - Power-on sets bit 0; only zero-write clears
// - Interrupt flag set on time-out with irq-enable; ack or one-write clears
// - Interrupt needs global and time-out enable
// - Enable and irq-enable pick stop, interrupt, reset or interrupt then reset
// - With enable set, time-out clears irq-enable
// - Change-enable self-clears four cycles after set
// - Enable clears only inside the change window
// - Time-out select changes only inside the window
// - Safety level 2 never disables the watchdog
// - Level 1: watchdog flag forces enable on
// - Codes 0..9 give 2048 doubling to 1048576 ticks
// - Counter advances on the 128 kHz slow tick
// - Counter restarts on kick, disable, chip reset
// - Time-out reset is a one-cycle pulse
// - Fuse selects level 1 or always-on level 2
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_regs.svh"

module watchdog_with_reset_flags
  import watchdog_pkg::*;
#(
  parameter int BASE_TICKS = `WDT_BASE_TICKS
)
(
  // Clock and power-on reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Device context
  input  wire logic        slow_tick_i,
  input  wire logic        kick_i,
  input  wire logic        always_on_fuse_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        irq_ack_i,
  input  wire logic        brownout_rst_i,
  input  wire logic        pin_rst_i,
  // Time-out outputs
  output logic             timeout_irq_o,
  output logic             wdt_reset_o
);

  logic        timeout_irq_flag;
  logic        timeout_irq_enable;
  logic        change_enable;
  logic [2:0]  ce_count;
  logic        enable_bit;
  logic [3:0]  timeout_select;
  logic        watchdog_cause_flag;
  logic        brownout_cause_flag;
  logic        pin_cause_flag;
  logic        poweron_cause_flag;
  logic [20:0] count;

  logic         level2;
  logic         enable_eff;
  logic         running;
  logic         timeout;
  logic         chip_rst;
  logic         wr_ctrl;
  logic         wr_stat;
  logic         addr_ok;
  wdt_mode_type mode;

  // Last tick of the selected period; reserved codes behave as the longest
  function automatic logic [20:0] period_last(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `WDT_SEL_MAX) ? `WDT_SEL_MAX : code;
    return 21'(BASE_TICKS << c) - 21'h1;
  endfunction

  function automatic logic [7:0] ctrl_image(input logic f, input logic ie,
                                            input logic ce, input logic en,
                                            input logic [3:0] sel);
    return {f, ie, sel[3], ce, en, sel[2:0]};
  endfunction

  assign level2     = always_on_fuse_i;
  // Level 1 lets the watchdog flag hold the enable on
  assign enable_eff = enable_bit | level2 | watchdog_cause_flag;
  assign mode       = wdt_mode_type'({enable_eff, timeout_irq_enable});
  assign running    = (mode != MODE_STOPPED);
  assign timeout    = running && slow_tick_i && (count == period_last(timeout_select));
  // Our own reset pulse resets the control state one cycle later
  assign chip_rst   = brownout_rst_i | pin_rst_i | wdt_reset_o;

  assign addr_ok = (paddr_i == `WDT_CTRL_ADDR) || (paddr_i == `WDT_STAT_ADDR);
  assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i
                   && (paddr_i == `WDT_CTRL_ADDR);
  assign wr_stat = psel_i && penable_i && pready_o && pwrite_i
                   && (paddr_i == `WDT_STAT_ADDR);

  // APB: answer is registered during the setup cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      prdata_o  <= 32'h0;
      if (psel_i && !penable_i && !pwrite_i)
      begin
        if (paddr_i == `WDT_CTRL_ADDR)
          prdata_o <= {24'h0, ctrl_image(timeout_irq_flag, timeout_irq_enable,
                                         change_enable, enable_eff, timeout_select)};
        else if (paddr_i == `WDT_STAT_ADDR)
          prdata_o <= {28'h0, watchdog_cause_flag, brownout_cause_flag,
                       pin_cause_flag, poweron_cause_flag};
      end
    end
  end

  // Slow-tick counter
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      count <= 21'h0;
    else if (chip_rst || kick_i || !running)
      count <= 21'h0;
    else if (slow_tick_i)
      count <= timeout ? 21'h0 : count + 21'h1;
  end

  // Time-out action
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wdt_reset_o <= 1'b0;
    else
      wdt_reset_o <= timeout && (mode == MODE_RESET);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_irq_o <= 1'b0;
    else
      timeout_irq_o <= timeout_irq_flag && timeout_irq_enable && global_irq_enable_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_irq_flag <= 1'b0;
    else if (timeout && timeout_irq_enable)
      timeout_irq_flag <= 1'b1;
    else if (irq_ack_i || (wr_ctrl && pwdata_i[`WDT_CTRL_IRQF_BIT]))
      timeout_irq_flag <= 1'b0;
  end

  // Hardware clear wins over a simultaneous software set
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_irq_enable <= 1'b0;
    else if (chip_rst)
      timeout_irq_enable <= 1'b0;
    else if (timeout && timeout_irq_enable && enable_eff)
      timeout_irq_enable <= 1'b0;
    else if (wr_ctrl)
      timeout_irq_enable <= pwdata_i[`WDT_CTRL_IE_BIT];
  end

  // Change window opens only when enable and change-enable are written together
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      change_enable <= 1'b0;
      ce_count      <= 3'h0;
    end
    else if (chip_rst)
    begin
      change_enable <= 1'b0;
      ce_count      <= 3'h0;
    end
    else if (wr_ctrl && pwdata_i[`WDT_CTRL_CE_BIT] && pwdata_i[`WDT_CTRL_WDE_BIT])
    begin
      change_enable <= 1'b1;
      ce_count      <= 3'h0;
    end
    else if (change_enable)
    begin
      ce_count <= ce_count + 3'h1;
      if (ce_count == `WDT_CE_CYCLES - 3'h1 || wr_ctrl)
        change_enable <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      enable_bit <= 1'b0;
    else if (chip_rst)
      enable_bit <= 1'b0;
    else if (wr_ctrl)
    begin
      if (pwdata_i[`WDT_CTRL_WDE_BIT])
        enable_bit <= 1'b1;
      else if (change_enable && !level2 && !watchdog_cause_flag)
        enable_bit <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_select <= `WDT_SEL_RESET;
    else if (chip_rst)
      timeout_select <= `WDT_SEL_RESET;
    else if (wr_ctrl && change_enable)
      timeout_select <= {pwdata_i[`WDT_CTRL_SEL3_BIT], pwdata_i[2:0]};
  end

  // Reset-cause flags: a set in the same cycle as a zero-write wins
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      watchdog_cause_flag <= 1'b0;
      brownout_cause_flag <= 1'b0;
      pin_cause_flag      <= 1'b0;
      poweron_cause_flag  <= `WDT_POWERON_CAUSE_FLAG_RESET;
    end
    else
    begin
      if (timeout && mode == MODE_RESET)
        watchdog_cause_flag <= 1'b1;
      else if (wr_stat && !pwdata_i[`WDT_STAT_WDRF_BIT])
        watchdog_cause_flag <= 1'b0;
      if (brownout_rst_i)
        brownout_cause_flag <= 1'b1;
      else if (wr_stat && !pwdata_i[`WDT_STAT_BROWNOUT_CAUSE_FLAG_BIT])
        brownout_cause_flag <= 1'b0;
      if (pin_rst_i)
        pin_cause_flag <= 1'b1;
      else if (wr_stat && !pwdata_i[`WDT_STAT_PIN_CAUSE_FLAG_BIT])
        pin_cause_flag <= 1'b0;
      if (wr_stat && !pwdata_i[`WDT_STAT_POWERON_CAUSE_FLAG_BIT])
        poweron_cause_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_window_opened;
    $rose(change_enable) && !wr_ctrl && !chip_rst ##1 (!wr_ctrl && !chip_rst)[*3];
  endsequence

  sequence seq_reset_timeout;
    timeout && mode == MODE_RESET;
  endsequence

  chk_reserved_zero: assert property (
    pready_o && !pwrite_i && paddr_i == `WDT_STAT_ADDR |-> prdata_o[7:4] == 4'h0)
    else $error("reserved status bits not zero");

  chk_wdog_flag_pulse: assert property (
    seq_reset_timeout |=> watchdog_cause_flag && wdt_reset_o ##1 !wdt_reset_o)
    else $error("watchdog reset did not flag or pulse once");

  chk_bod_flag: assert property (
    brownout_rst_i |=> brownout_cause_flag)
    else $error("brown-out flag not set");

  chk_pin_flag: assert property (
    pin_rst_i |=> pin_cause_flag)
    else $error("pin reset flag not set");

  chk_irq_flag_set: assert property (
    timeout && timeout_irq_enable |=> timeout_irq_flag)
    else $error("time-out interrupt flag not set");

  chk_irq_gate: assert property (
    timeout_irq_o |-> $past(timeout_irq_flag && timeout_irq_enable && global_irq_enable_i))
    else $error("interrupt raised without both enables");

  chk_ie_autoclear: assert property (
    timeout && timeout_irq_enable && enable_eff |=> !timeout_irq_enable)
    else $error("irq enable not cleared at time-out");

  chk_window_expiry: assert property (
    seq_window_opened |=> !change_enable)
    else $error("change window not closed after four cycles");

  chk_select_locked: assert property (
    wr_ctrl && !change_enable && !chip_rst |=> $stable(timeout_select))
    else $error("time-out select changed outside window");

  chk_level2_on: assert property (
    level2 && wr_ctrl && change_enable && !pwdata_i[`WDT_CTRL_WDE_BIT] && !chip_rst
      |=> $stable(enable_bit))
    else $error("watchdog disabled in level 2");

  chk_level1_forced: assert property (
    !level2 && watchdog_cause_flag && wr_ctrl && change_enable && !chip_rst
      |=> !$fell(enable_bit))
    else $error("enable cleared while watchdog flag set");

  chk_kick_restart: assert property (
    kick_i |=> count == 21'h0)
    else $error("counter not restarted by kick");

endmodule // watchdog_with_reset_flags
`default_nettype wire
